// ---- rtl/urc_pkg.sv ----
// Shared constants and types for the UAT Reed-Solomon message classifier.
// Assumes both link ends and the consumer run on one 125 MHz receive clock.
package urc_pkg;
    // Symbol and code geometry
    localparam int SYM_W = 8;
    localparam int BASIC_N = 30;
    localparam int BASIC_K = 18;
    localparam int LONG_N = 48;
    localparam int LONG_K = 34;
    localparam int UP_N = 92;
    localparam int UP_K = 72;
    localparam int UP_WORDS = 6;
    localparam int ADSB_LEN = LONG_N;
    localparam int UP_LEN = UP_N * UP_WORDS;
    // Largest correction power of all three codes
    localparam int T_MAX = (UP_N - UP_K) / 2;
    localparam int IDX_W = 10;
    // Type code field in the first information byte
    localparam int TC_MSB = 7;
    localparam int TC_LSB = 3;
    // Field arithmetic defaults, overridable per instance
    localparam logic [7:0] GF_POLY_DFLT = 8'h1d;
    localparam int FCR_DFLT = 0;

    // Outcome reported with each result beat
    typedef enum logic [2:0] {
        URC_K_NONE,
        URC_K_LONG,
        URC_K_BASIC,
        URC_K_DISCARD,
        URC_K_UP_OK,
        URC_K_UP_FAIL
    } urc_kind_t;
endpackage

// ---- rtl/urc_link_if.sv ----
// Byte link from the demodulator/sync front end to the classifier.
// Assumes both modules share CLK; ready is combinational from the classifier.
`timescale 1ns/1ps
`default_nettype none
interface urc_link_if;
    logic sync;
    logic uplink;
    logic valid;
    logic [7:0] data;
    logic ready;

    modport dev(input sync, input uplink, input valid, input data, output ready);
    modport fe(output sync, output uplink, output valid, output data, input ready);
endinterface
`default_nettype wire

// ---- rtl/urc_front_end.sv ----
// Front-end side of the classifier link: frames raw received bytes.
// Assumes the demodulator delivers whole frames after each sync detection.
`timescale 1ns/1ps
`default_nettype none
module urc_front_end (
    input wire logic CLK, // Receive clock
    input wire logic SYS_RST, // Synchronous reset, active high
    urc_link_if.fe LNK, // Link to the classifier
    input wire logic FRM_START, // Sync pattern detected, one-cycle pulse
    input wire logic FRM_UPLINK, // Detected pattern was the uplink one
    input wire logic BYTE_VALID, // Raw byte present
    input wire logic [7:0] BYTE_DATA, // Raw received byte
    output logic FRM_READY, // Start or byte would be taken now
    output logic FRM_ACTIVE // Frame in progress
);
    localparam int IW = urc_pkg::IDX_W;
    localparam logic [IW-1:0] ADSB_LAST = IW'(urc_pkg::ADSB_LEN - 1);
    localparam logic [IW-1:0] UP_LAST = IW'(urc_pkg::UP_LEN - 1);

    logic active_r;
    logic uplink_r;
    logic sync_r;
    logic valid_r;
    logic [7:0] data_r;
    logic [IW-1:0] cnt_r;

    // Frame sequencing; a start is only taken while the classifier is idle
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            active_r <= 1'b0;
            uplink_r <= 1'b0;
            sync_r <= 1'b0;
            valid_r <= 1'b0;
            data_r <= 8'h00;
            cnt_r <= '0;
        end else begin
            sync_r <= 1'b0;
            valid_r <= 1'b0;
            if (!active_r) begin
                if (FRM_START && LNK.ready) begin
                    sync_r <= 1'b1;
                    uplink_r <= FRM_UPLINK;
                    active_r <= 1'b1;
                    cnt_r <= '0;
                end
            end else if (BYTE_VALID) begin
                valid_r <= 1'b1;
                data_r <= BYTE_DATA;
                cnt_r <= cnt_r + IW'(1);
                // ADS-B frames carry 48 bytes, uplink frames six 92-byte words
                if (cnt_r == (uplink_r ? UP_LAST : ADSB_LAST)) begin
                    active_r <= 1'b0;
                end
            end
        end
    end

    // Link drive straight from flops
    assign LNK.sync = sync_r;
    assign LNK.uplink = uplink_r;
    assign LNK.valid = valid_r;
    assign LNK.data = data_r;
    assign FRM_READY = active_r | LNK.ready;
    assign FRM_ACTIVE = active_r;
endmodule
`default_nettype wire

// ---- rtl/urc_classifier.sv ----
// Reed-Solomon decoder and message length classifier for UAT receive.
// Assumes bytes arrive over urc_link_if and the consumer never stalls output.
`timescale 1ns/1ps
`default_nettype none
module urc_classifier #(
    parameter logic [7:0] GF_POLY = urc_pkg::GF_POLY_DFLT, // Field polynomial low byte
    parameter int FCR = urc_pkg::FCR_DFLT, // Power of first syndrome root
    parameter bit CHK_LONG_TC = 1'b0 // Reject long results with zero type code
) (
    input wire logic CLK, // Receive clock
    input wire logic SYS_RST, // Synchronous reset, active high
    urc_link_if.dev LNK, // Bytes from the front end
    output logic OUT_VALID, // Result beat present
    output logic OUT_LAST, // Last beat of this outcome
    output var urc_pkg::urc_kind_t OUT_KIND, // Outcome class
    output logic [7:0] OUT_DATA, // Corrected information byte
    output logic BUSY // Frame held or being decoded
);
    localparam int TM = urc_pkg::T_MAX;
    localparam int IW = urc_pkg::IDX_W;
    localparam logic [IW-1:0] UPN = IW'(urc_pkg::UP_N);

    typedef enum logic [3:0] {
        S_IDLE, S_RECV, S_LAUNCH, S_SYND, S_BM, S_OMEGA, S_CHIEN, S_DECIDE, S_COMMIT,
        S_ADV, S_EMIT
    } urc_state_t;
    typedef enum logic [1:0] {P_LONG, P_BASIC, P_UP} urc_pass_t;

    // Byte-wide field multiply, one symbol per byte
    function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) p ^= x;
            x = x[7] ? ({x[6:0], 1'b0} ^ GF_POLY) : {x[6:0], 1'b0};
        end
        return p;
    endfunction

    // Power of the primitive element; folds to a constant for constant e
    function automatic logic [7:0] gf_exp(input int e);
        logic [7:0] r;
        r = 8'h01;
        for (int i = 0; i < 255; i++) begin
            if (i < e) r = gf_mul(r, 8'h02);
        end
        return r;
    endfunction

    // Inverse as a^254, square and multiply to keep the chain short
    function automatic logic [7:0] gf_inv(input logic [7:0] a);
        logic [7:0] p;
        logic [7:0] r;
        p = a;
        r = 8'h01;
        for (int i = 0; i < 7; i++) begin
            p = gf_mul(p, p);
            r = gf_mul(r, p);
        end
        return r;
    endfunction

    urc_state_t st_r;
    urc_pass_t pass_r;
    urc_pkg::urc_kind_t kind_r;
    logic [7:0] mem [urc_pkg::UP_LEN];
    logic uplink_r, ok_r, acc_r, upfail_r;
    logic [IW-1:0] wcnt_r, n_r, base_r, idx_r, eoff_r;
    logic [2:0] word_r, ew_r;
    logic [4:0] tcur_r, len_r, ecnt_r;
    logic [7:0] syn_r [2*TM];
    logic [7:0] lam_r [TM+1];
    logic [7:0] bb_r [TM+1];
    logic [7:0] lt_r [TM+1];
    logic [7:0] om_r [TM];
    logic [7:0] ot_r [TM];
    logic [7:0] xc_r;
    logic [IW-1:0] ep_r [TM];
    logic [7:0] ev_r [TM];
    logic [IW-1:0] rd_addr, klen, flen;
    logic [7:0] mem_rd, conv, dinv, lsum, osum, odd, fix0;
    logic emit_one, emit_end, fin;

    // Shared read port for syndrome pass, type code check and output
    always_comb begin
        rd_addr = base_r;
        if (st_r == S_SYND) rd_addr = base_r + idx_r;
        if (st_r == S_EMIT) rd_addr = IW'(ew_r) * UPN + eoff_r;
    end
    assign mem_rd = mem[rd_addr];
    assign flen = uplink_r ? IW'(urc_pkg::UP_LEN) : IW'(urc_pkg::ADSB_LEN);

    // Locator times syndromes at idx: discrepancy in BM, evaluator afterwards
    always_comb begin
        conv = 8'h00;
        for (int i = 0; i <= TM; i++) begin
            if (i <= int'(idx_r)) conv ^= gf_mul(lam_r[i], syn_r[int'(idx_r) - i]);
        end
    end
    assign dinv = gf_inv(conv);

    // Chien sums and Forney magnitude for the current position
    always_comb begin
        lsum = 8'h00;
        odd = 8'h00;
        osum = 8'h00;
        for (int k = 0; k <= TM; k++) begin
            lsum ^= lt_r[k];
            if (k % 2 == 1) odd ^= lt_r[k];
            if (k < TM) osum ^= ot_r[k];
        end
    end

    // First information byte as it would read after correction
    always_comb begin
        fix0 = mem_rd;
        for (int i = 0; i < TM; i++) begin
            if (i < int'(ecnt_r) && ep_r[i] == '0) fix0 ^= ev_r[i];
        end
    end
    assign fin = ok_r && (ecnt_r == len_r);

    // Output length and end of the emission
    always_comb begin
        klen = IW'(urc_pkg::UP_K);
        if (kind_r == urc_pkg::URC_K_LONG) klen = IW'(urc_pkg::LONG_K);
        if (kind_r == urc_pkg::URC_K_BASIC) klen = IW'(urc_pkg::BASIC_K);
    end
    assign emit_one = kind_r == urc_pkg::URC_K_DISCARD || kind_r == urc_pkg::URC_K_UP_FAIL;
    assign emit_end = emit_one || (eoff_r == klen - IW'(1) &&
        (kind_r != urc_pkg::URC_K_UP_OK || ew_r == 3'(urc_pkg::UP_WORDS - 1)));

    // Frame store; a rejected decode must leave raw bytes for the next pass
    always_ff @(posedge CLK) begin
        if (st_r == S_RECV && LNK.valid) begin
            mem[wcnt_r] <= LNK.data;
        end else if (st_r == S_COMMIT && acc_r && idx_r < IW'(ecnt_r)) begin
            mem[base_r + ep_r[idx_r[3:0]]] <= mem[base_r + ep_r[idx_r[3:0]]] ^ ev_r[idx_r[3:0]];
        end
    end

    // Decode sequencer; decodes run one after another, decision order fixed
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            st_r <= S_IDLE;
            pass_r <= P_LONG;
            kind_r <= urc_pkg::URC_K_NONE;
            {uplink_r, ok_r, acc_r, upfail_r} <= 4'h0;
            {wcnt_r, n_r, base_r, idx_r} <= '0;
            {word_r, tcur_r, len_r, ecnt_r} <= '0;
            xc_r <= 8'h00;
            for (int j = 0; j < 2 * TM; j++) syn_r[j] <= 8'h00;
            for (int j = 0; j <= TM; j++) begin
                lam_r[j] <= 8'h00;
                bb_r[j] <= 8'h00;
                lt_r[j] <= 8'h00;
            end
            for (int j = 0; j < TM; j++) begin
                om_r[j] <= 8'h00;
                ot_r[j] <= 8'h00;
                ep_r[j] <= '0;
                ev_r[j] <= 8'h00;
            end
        end else begin
            unique case (st_r)
                S_IDLE: if (LNK.sync) begin
                    uplink_r <= LNK.uplink;
                    pass_r <= LNK.uplink ? P_UP : P_LONG;
                    wcnt_r <= '0;
                    word_r <= 3'h0;
                    upfail_r <= 1'b0;
                    st_r <= S_RECV;
                end
                S_RECV: if (LNK.valid) begin
                    wcnt_r <= wcnt_r + IW'(1);
                    if (wcnt_r == flen - IW'(1)) st_r <= S_LAUNCH;
                end
                S_LAUNCH: begin
                    unique case (pass_r)
                        P_LONG: begin
                            n_r <= IW'(urc_pkg::LONG_N);
                            base_r <= '0;
                        end
                        P_BASIC: begin
                            n_r <= IW'(urc_pkg::BASIC_N);
                            base_r <= '0;
                        end
                        P_UP: begin
                            n_r <= UPN;
                            base_r <= IW'(word_r) * UPN;
                        end
                    endcase
                    unique case (pass_r)
                        P_LONG: tcur_r <= 5'((urc_pkg::LONG_N - urc_pkg::LONG_K) / 2);
                        P_BASIC: tcur_r <= 5'((urc_pkg::BASIC_N - urc_pkg::BASIC_K) / 2);
                        P_UP: tcur_r <= 5'(TM);
                    endcase
                    for (int j = 0; j < 2 * TM; j++) syn_r[j] <= 8'h00;
                    idx_r <= '0;
                    st_r <= S_SYND;
                end
                // Hard symbols only; every byte weighs the same, nothing erased
                S_SYND: begin
                    for (int j = 0; j < 2 * TM; j++) begin
                        if (j < 2 * int'(tcur_r)) begin
                            syn_r[j] <= gf_mul(syn_r[j], gf_exp((FCR + j) % 255)) ^ mem_rd;
                        end
                    end
                    idx_r <= idx_r + IW'(1);
                    if (idx_r == n_r - IW'(1)) begin
                        idx_r <= '0;
                        len_r <= 5'h00;
                        for (int j = 0; j <= TM; j++) begin
                            lam_r[j] <= (j == 0) ? 8'h01 : 8'h00;
                            bb_r[j] <= (j == 0) ? 8'h01 : 8'h00;
                        end
                        st_r <= S_BM;
                    end
                end
                // Berlekamp-Massey with the old locator prescaled by 1/d
                S_BM: begin
                    for (int j = 0; j <= TM; j++) begin
                        if (j > 0) lam_r[j] <= lam_r[j] ^ gf_mul(conv, bb_r[j-1]);
                        if (conv != 8'h00 && 2 * int'(len_r) <= int'(idx_r)) begin
                            bb_r[j] <= gf_mul(lam_r[j], dinv);
                        end else begin
                            bb_r[j] <= (j > 0) ? bb_r[j-1] : 8'h00;
                        end
                    end
                    if (conv != 8'h00 && 2 * int'(len_r) <= int'(idx_r)) begin
                        len_r <= 5'(idx_r) + 5'h01 - len_r;
                    end
                    idx_r <= idx_r + IW'(1);
                    if (idx_r == IW'({tcur_r, 1'b0}) - IW'(1)) begin
                        idx_r <= '0;
                        st_r <= S_OMEGA;
                    end
                end
                S_OMEGA: begin
                    om_r[idx_r[3:0]] <= conv;
                    idx_r <= idx_r + IW'(1);
                    if (idx_r == IW'(TM - 1)) begin
                        for (int j = 0; j <= TM; j++) lt_r[j] <= lam_r[j];
                        for (int j = 0; j < TM - 1; j++) ot_r[j] <= om_r[j];
                        ot_r[TM-1] <= conv;
                        xc_r <= 8'h01;
                        ecnt_r <= 5'h00;
                        idx_r <= '0;
                        // Locator longer than t means too many bad bytes
                        ok_r <= len_r <= tcur_r;
                        st_r <= (len_r <= tcur_r) ? S_CHIEN : S_DECIDE;
                    end
                end
                // Position p counts from the last byte of the word backwards
                S_CHIEN: begin
                    if (lsum == 8'h00) begin
                        if (ecnt_r == 5'(TM) || odd == 8'h00) begin
                            ok_r <= 1'b0;
                        end else begin
                            ep_r[ecnt_r[3:0]] <= n_r - IW'(1) - idx_r;
                            ev_r[ecnt_r[3:0]] <= gf_mul(gf_mul(xc_r, osum), gf_inv(odd));
                            ecnt_r <= ecnt_r + 5'h01;
                        end
                    end
                    for (int j = 0; j <= TM; j++) begin
                        lt_r[j] <= gf_mul(lt_r[j], gf_exp((255 - j) % 255));
                    end
                    for (int j = 0; j < TM; j++) begin
                        ot_r[j] <= gf_mul(ot_r[j], gf_exp((255 - j) % 255));
                    end
                    xc_r <= gf_mul(xc_r, gf_exp((255 - (FCR % 255)) % 255));
                    idx_r <= idx_r + IW'(1);
                    if (idx_r == n_r - IW'(1)) st_r <= S_DECIDE;
                end
                // Type code checked on the would-be corrected first byte
                S_DECIDE: begin
                    unique case (pass_r)
                        P_LONG: acc_r <= fin && !(CHK_LONG_TC &&
                            fix0[urc_pkg::TC_MSB:urc_pkg::TC_LSB] == 5'h00);
                        P_BASIC: acc_r <= fin &&
                            fix0[urc_pkg::TC_MSB:urc_pkg::TC_LSB] == 5'h00;
                        P_UP: acc_r <= fin;
                    endcase
                    idx_r <= '0;
                    st_r <= S_COMMIT;
                end
                // Corrections reach the store only once accepted
                S_COMMIT: begin
                    idx_r <= idx_r + IW'(1);
                    if (!acc_r || idx_r + IW'(1) >= IW'(ecnt_r)) st_r <= S_ADV;
                end
                S_ADV: begin
                    st_r <= S_EMIT;
                    unique case (pass_r)
                        P_LONG: if (acc_r) begin
                            kind_r <= urc_pkg::URC_K_LONG;
                        end else begin
                            pass_r <= P_BASIC;
                            st_r <= S_LAUNCH;
                        end
                        P_BASIC: kind_r <= acc_r ? urc_pkg::URC_K_BASIC :
                            urc_pkg::URC_K_DISCARD;
                        P_UP: begin
                            upfail_r <= upfail_r | !acc_r;
                            if (word_r == 3'(urc_pkg::UP_WORDS - 1)) begin
                                kind_r <= (upfail_r | !acc_r) ? urc_pkg::URC_K_UP_FAIL :
                                    urc_pkg::URC_K_UP_OK;
                            end else begin
                                word_r <= word_r + 3'h1;
                                st_r <= S_LAUNCH;
                            end
                        end
                    endcase
                end
                S_EMIT: if (emit_end) st_r <= S_IDLE;
            endcase
        end
    end

    // Result stream; single beat for discarded or failed frames
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            OUT_VALID <= 1'b0;
            OUT_LAST <= 1'b0;
            OUT_KIND <= urc_pkg::URC_K_NONE;
            OUT_DATA <= 8'h00;
            eoff_r <= '0;
            ew_r <= 3'h0;
        end else if (st_r == S_EMIT) begin
            OUT_VALID <= 1'b1;
            OUT_LAST <= emit_end;
            OUT_KIND <= kind_r;
            OUT_DATA <= emit_one ? 8'h00 : mem_rd;
            eoff_r <= eoff_r + IW'(1);
            if (eoff_r == klen - IW'(1)) begin
                eoff_r <= '0;
                ew_r <= ew_r + 3'h1;
            end
        end else begin
            OUT_VALID <= 1'b0;
            OUT_LAST <= 1'b0;
            eoff_r <= '0;
            ew_r <= 3'h0;
        end
    end

    // Only an idle classifier takes a new sync, so no outcome is lost
    assign LNK.ready = st_r == S_IDLE;
    assign BUSY = st_r != S_IDLE;
endmodule
`default_nettype wire

// ---- verification/urc_link_assertions.sv ----
// Checker for the classifier link and the result stream.
// Assumes one clock; instantiated beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module urc_link_assertions (
    input wire logic CLK, // Receive clock
    input wire logic SYS_RST, // Sync reset
    input wire logic sync, // Frame start
    input wire logic ready, // Classifier idle
    input wire logic OUT_VALID, // Result beat
    input wire logic OUT_LAST, // Last beat
    input var urc_pkg::urc_kind_t OUT_KIND, // Outcome class
    input wire logic [7:0] OUT_DATA, // Result byte
    input wire logic BUSY // Not idle
);
    logic [9:0] beats_r;

    // Beats seen so far; cleared by the last beat so each outcome counts alone
    always_ff @(posedge CLK) begin
        if (SYS_RST || (OUT_VALID && OUT_LAST)) begin
            beats_r <= 10'h000;
        end else if (OUT_VALID) begin
            beats_r <= beats_r + 10'h001;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    chk_long_beats: assert property (
        OUT_VALID && OUT_LAST && OUT_KIND == urc_pkg::URC_K_LONG |-> beats_r == 10'h021)
        else $error("long outcome beat count wrong");
    chk_basic_beats: assert property (
        OUT_VALID && OUT_LAST && OUT_KIND == urc_pkg::URC_K_BASIC |-> beats_r == 10'h011)
        else $error("basic outcome beat count wrong");
    chk_uplink_beats: assert property (
        OUT_VALID && OUT_LAST && OUT_KIND == urc_pkg::URC_K_UP_OK |-> beats_r == 10'h1af)
        else $error("uplink outcome beat count wrong");
    chk_single_beat: assert property (
        OUT_VALID && (OUT_KIND == urc_pkg::URC_K_DISCARD || OUT_KIND == urc_pkg::URC_K_UP_FAIL)
        |-> OUT_LAST && OUT_DATA == 8'h00) else $error("failed outcome not a single empty beat");
    chk_last_release: assert property (
        OUT_VALID && OUT_LAST |=> ready && !OUT_VALID) else $error("no release after last beat");
    chk_beat_run: assert property (
        OUT_VALID && !OUT_LAST |=> OUT_VALID && $stable(OUT_KIND))
        else $error("outcome beats broken or kind changed");
    chk_sync_taken: assert property (
        sync |-> ready ##1 BUSY) else $error("start not taken while idle");
    chk_beats_busy: assert property (
        OUT_VALID && !OUT_LAST |-> BUSY) else $error("outcome beat while classifier idle");

    // Main outcomes reached
    cov_long: cover property (OUT_VALID && OUT_LAST && OUT_KIND == urc_pkg::URC_K_LONG);
    cov_basic: cover property (OUT_VALID && OUT_LAST && OUT_KIND == urc_pkg::URC_K_BASIC);
    cov_upfail: cover property (OUT_VALID && OUT_KIND == urc_pkg::URC_K_UP_FAIL);
    cov_up_ok: cover property (OUT_VALID && OUT_LAST && OUT_KIND == urc_pkg::URC_K_UP_OK);
endmodule
`default_nettype wire

// ---- verification/urc_classifier_tb.sv ----
// Bench: front end and classifier joined over the link, user sides driven here.
// Assumes default field settings; only the all-zero code word is sent, plus faults.
`timescale 1ns/1ps
`default_nettype none
module urc_classifier_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic frm_start = 1'b0;
    logic frm_uplink = 1'b0;
    logic byte_valid = 1'b0;
    logic [7:0] byte_data = 8'h00;
    logic frm_ready;
    logic frm_active;
    logic out_valid;
    logic out_last;
    urc_pkg::urc_kind_t out_kind;
    logic [7:0] out_data;
    logic busy;
    logic [7:0] frame [0:urc_pkg::UP_LEN-1];
    int err_total = 0;
    int num_checks = 0;
    urc_link_if lnk ();

    // 125 MHz clock
    always #4 clk = ~clk;

    urc_front_end urc_front_end_i (.CLK(clk), .SYS_RST(sys_rst), .LNK(lnk),
        .FRM_START(frm_start), .FRM_UPLINK(frm_uplink), .BYTE_VALID(byte_valid),
        .BYTE_DATA(byte_data), .FRM_READY(frm_ready), .FRM_ACTIVE(frm_active));
    urc_classifier urc_classifier_i (.CLK(clk), .SYS_RST(sys_rst), .LNK(lnk),
        .OUT_VALID(out_valid), .OUT_LAST(out_last), .OUT_KIND(out_kind),
        .OUT_DATA(out_data), .BUSY(busy));
    urc_link_assertions urc_link_assertions_i (.CLK(clk), .SYS_RST(sys_rst),
        .sync(lnk.sync), .ready(lnk.ready), .OUT_VALID(out_valid), .OUT_LAST(out_last),
        .OUT_KIND(out_kind), .OUT_DATA(out_data), .BUSY(busy));

    task automatic test_done();
        if (err_total == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Zero code word, noise bytes from noise_at on (never zero)
    task automatic clear(input int len, input int noise_at);
        for (int i = 0; i < len; i++) begin
            frame[i] = (i >= noise_at) ? 8'(i | 1) : 8'h00;
        end
    endtask

    // Bad bytes spaced by three so a word's count is exact
    task automatic corrupt(input int first, input int nerr);
        for (int i = 0; i < nerr; i++) begin
            frame[first + 3 * i] = 8'(8'h81 + i);
        end
    endtask

    // Wait for idle, then a start and len bytes back to back
    task automatic send_frame(input logic up, input int len);
        int n;
        n = 0;
        while (!(frm_ready === 1'b1 && frm_active === 1'b0) && n < 20000) begin
            @(negedge clk);
            n++;
        end
        if (n == 20000) begin
            err_total++;
            test_done();
        end
        frm_uplink = up;
        frm_start = 1'b1;
        @(negedge clk);
        frm_start = 1'b0;
        for (int i = 0; i < len; i++) begin
            byte_valid = 1'b1;
            byte_data = frame[i];
            @(negedge clk);
        end
        byte_valid = 1'b0;
    endtask

    // Outcome beats: kind, zero data, last flag only on the final beat
    task automatic collect(input urc_pkg::urc_kind_t kind, input int beats);
        int n;
        n = 0;
        while (out_valid !== 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        if (n == 20000) begin
            err_total++;
            test_done();
        end
        for (int i = 0; i < beats; i++) begin
            check("valid", 10'(out_valid), 10'h001);
            check("kind", 10'(out_kind), 10'(kind));
            check("data", 10'(out_data), 10'h000);
            check("last", 10'(out_last), 10'(i == beats - 1));
            @(negedge clk);
        end
        check("valid after last", 10'(out_valid), 10'h000);
    endtask

    // Clean word (basic would pass too) and seven bad bytes incl. type byte
    task automatic t_long();
        for (int e = 0; e < 8; e += 7) begin
            clear(urc_pkg::LONG_N, urc_pkg::LONG_N);
            corrupt(0, e);
            send_frame(1'b0, urc_pkg::ADSB_LEN);
            collect(urc_pkg::URC_K_LONG, urc_pkg::LONG_K);
        end
    endtask

    // Basic frame with six bad bytes and a noise tail
    task automatic t_basic();
        clear(urc_pkg::LONG_N, urc_pkg::BASIC_N);
        corrupt(0, 6);
        send_frame(1'b0, urc_pkg::ADSB_LEN);
        collect(urc_pkg::URC_K_BASIC, urc_pkg::BASIC_K);
    endtask

    // Eight bad bytes defeat the long code; two fall in the basic part
    task automatic t_long_fail();
        clear(urc_pkg::LONG_N, urc_pkg::LONG_N);
        corrupt(24, 8);
        send_frame(1'b0, urc_pkg::ADSB_LEN);
        collect(urc_pkg::URC_K_BASIC, urc_pkg::BASIC_K);
    endtask

    // Seven bad bytes in the basic part: both decodes fail
    task automatic t_discard();
        clear(urc_pkg::LONG_N, urc_pkg::BASIC_N);
        corrupt(0, 7);
        send_frame(1'b0, urc_pkg::ADSB_LEN);
        collect(urc_pkg::URC_K_DISCARD, 1);
    endtask

    // Ten bad bytes per word; one more in the last word when bad is set
    task automatic t_uplink(input logic bad);
        clear(urc_pkg::UP_LEN, urc_pkg::UP_LEN);
        for (int w = 0; w < urc_pkg::UP_WORDS; w++) begin
            corrupt(w * urc_pkg::UP_N + 5, 10 + int'(bad && w == 5));
        end
        send_frame(1'b1, urc_pkg::UP_LEN);
        if (bad) begin
            collect(urc_pkg::URC_K_UP_FAIL, 1);
        end else begin
            collect(urc_pkg::URC_K_UP_OK, urc_pkg::UP_K * urc_pkg::UP_WORDS);
        end
    endtask

    // Reset, idle values, then frames back to back
    initial begin
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        check("ready", 10'(frm_ready), 10'h001);
        check("busy", 10'(busy), 10'h000);
        t_long();
        t_basic();
        t_long_fail();
        t_discard();
        t_uplink(1'b0);
        t_uplink(1'b1);
        test_done();
    end
endmodule
`default_nettype wire
